// ==== src/crs_card.sv ====
// Summary of operation
// RQ1 - controller reads identity only after power-up
// RQ2 - identity output enabled only while selected
// RQ3 - clear pulse zeroes rom address counter
// RQ4 - advance low increments counter, holds load
// RQ5 - controller holds advance low until settled
// RQ6 - first byte sent comes from location one
// RQ7 - eight loaded bits shift out per clock
// RQ8 - msb first, high impedance between bytes
// RQ9 - controller repeats until 498 bytes read
// RQ10 - image holds identity, settling, relay table
// RQ11 - one link clock serves both streams
// RQ12 - sixteen bytes shifted, twelve kept here
// RQ13 - stages shift and cascade to next
// RQ14 - strobe copies shift chain into latches
// RQ15 - low output energizes, high leaves off
// RQ16 - outputs disabled after power-up
// RQ17 - first strobe clears safeguard, enables outputs
// RQ18 - hold-off before safeguard accepts strobe
// RQ19 - counter covers locations 1 to 498
module crs_card
  import crs_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES = CRS_HOLDOFF_CYCLES
) (
  // clock, reset, enable
  input  logic                      clk,
  input  logic                      reset_n,
  input  logic                      clk_en,
  // backplane inputs
  input  crs_pkg::crs_pins_t        pins,
  // identification data pin
  output logic                      identity_serial_out,
  output logic                      identity_serial_oe,
  // relay drivers
  output logic [CRS_RELAY_BITS-1:0] relay_drive_n,
  output logic                      driver_output_enable_n,
  output logic                      relay_serial_cascade
);
  import crs_pkg::*;

  // pin synchronisers and filtered levels
  // filt_prev_q keeps last cycle's level for the edge detectors
  logic [CRS_PIN_W-1:0] sync1_q;
  logic [CRS_PIN_W-1:0] sync2_q;
  logic [CRS_PIN_W-1:0] sync3_q;
  logic [CRS_PIN_W-1:0] filt_q;
  logic [CRS_PIN_W-1:0] filt_prev_q;
  crs_pins_t            lvl;
  crs_pins_t            lvl_prev;

  // identification path
  // nine address bits: 498 locations never wrap the counter
  logic [7:0]              id_rom [CRS_ROM_DEPTH];
  logic [CRS_ROM_AW-1:0]   addr_q;
  logic [7:0]              id_shift_q;
  logic [CRS_BITCNT_W-1:0] bits_left_q;
  logic                    id_out_q;
  logic                    id_oe_q;

  // relay path
  // chain_q is the shift side, latch_q the storage side
  logic [CRS_RELAY_BITS-1:0] chain_q;
  logic [CRS_RELAY_BITS-1:0] latch_q;
  logic [CRS_RELAY_BITS-1:0] drive_n_q;
  logic                      cascade_q;
  logic [CRS_STAGES-1:0]     stage_in;

  // safeguard: state, hold-off counter and registered enable;
  // the counter is wide enough for the full hold-off at 200 MHz
  crs_guard_t            guard_q;
  logic [CRS_HOLD_W-1:0] hold_cnt_q;
  logic                  oe_n_q;

  // derived events (edges one clock wide, loading a level), taken from filtered levels
  // so that a single noisy sample never counts twice
  logic link_rise;
  logic advance_fall;
  logic loading;

  // three-stage synchroniser per pin; a change counts once
  // stages two and three agree, which also rejects single glitches.
  // the price is latency: a pin edge reaches the filtered level four
  // clocks later, so the controller must hold every level for at
  // least two clocks; at 200 MHz that is far inside any link period
  for (genvar i = 0; i < CRS_PIN_W; i++) begin : g_sync
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        sync1_q[i] <= CRS_PINS_RST[i];
        sync2_q[i] <= CRS_PINS_RST[i];
        sync3_q[i] <= CRS_PINS_RST[i];
      end else if (clk_en) begin
        sync1_q[i] <= pins[i];
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
      end
    end

    // glitch filter and previous level for the edge detectors
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        filt_q[i]      <= CRS_PINS_RST[i];
        filt_prev_q[i] <= CRS_PINS_RST[i];
      end else if (clk_en) begin
        if (sync2_q[i] == sync3_q[i]) begin
          filt_q[i] <= sync3_q[i];
        end
        filt_prev_q[i] <= filt_q[i];
      end
    end
  end

  // edge detection on the filtered levels; both copies reset to the
  // idle level of each pin, so no false edge follows reset
  always_comb begin
    lvl          = crs_pins_t'(filt_q);
    lvl_prev     = crs_pins_t'(filt_prev_q);
    // RQ11 single link clock
    link_rise    = lvl.link_clk && !lvl_prev.link_clk;
    // the advance edge steps the counter; its level holds the load
    advance_fall = !lvl.rom_address_advance_n && lvl_prev.rom_address_advance_n;
    // RQ4 level-sensitive load
    loading      = !lvl.rom_address_advance_n;
  end

  // image table is constant logic; a real card would hold it in a
  // mask or fuse array, this keeps it visible to simulation
  // RQ10 identity, settling time and relay table image
  for (genvar a = 0; a < CRS_ROM_DEPTH; a++) begin : g_rom
    assign id_rom[a] = crs_rom_byte(a);
  end

  // address counter: nine bits reach past the last image location
  // clear wins over advance, so a late advance cannot skip location 1
  // the counter moves only on the advance edge, never on its level
  // RQ19 no wrap below 498
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= '0;
    end else if (clk_en) begin
      if (lvl.rom_address_clear) begin
        // RQ3 clear to zero
        addr_q <= '0;
      end else if (advance_fall) begin
        // RQ4 increment on advance
        addr_q <= addr_q + 1'b1;
      end
    end
  end

  // parallel-to-serial converter; the load reads the counter one
  // cycle after the increment, so location 0 is loaded only if advance is held low across a clear.
  // load dominates shifting: link rises while advance is low are
  // dropped, and once eight bits are out further rises do nothing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      id_shift_q  <= '0;
      bits_left_q <= '0;
    end else if (clk_en) begin
      if (loading && !advance_fall) begin
        // RQ6 load from incremented address
        id_shift_q  <= id_rom[addr_q];
        bits_left_q <= CRS_BITS_FULL;
      end else if (link_rise && bits_left_q != '0) begin
        // RQ7 one bit per link clock
        id_shift_q  <= {id_shift_q[CRS_BYTE_BITS-2:0], 1'b0};
        bits_left_q <= bits_left_q - 1'b1;
      end
    end
  end

  // identification pin: msb first, released once the byte is out.
  // the enable is registered with the data so both change on the
  // same clock and the pin never shows a half-shifted bit; a
  // deselected card shifts silently with the pin released
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      id_out_q <= 1'b0;
      id_oe_q  <= 1'b0;
    end else if (clk_en) begin
      // RQ8 msb first
      id_out_q <= id_shift_q[CRS_BYTE_BITS-1];
      // RQ2 drive only while selected
      id_oe_q  <= !lvl.card_select_n && (bits_left_q != '0);
    end
  end

  // relay shift chain: each stage takes the top bit of the one
  // before; stage 0 takes the serial input. the chain also moves
  // during identification readout, which is harmless because only
  // a strobe reaches the latches
  for (genvar s = 0; s < CRS_STAGES; s++) begin : g_stage
    localparam int unsigned LO = s * CRS_BYTE_BITS;
    // serial input of this stage: backplane line or previous cascade
    if (s == 0) begin : g_head
      assign stage_in[s] = lvl.relay_serial_in;
    end else begin : g_tail
      // RQ13 cascade from stage before
      assign stage_in[s] = chain_q[LO-1];
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        chain_q[LO +: CRS_BYTE_BITS] <= '0;
      end else if (clk_en && link_rise) begin
        // RQ13 shift and cascade
        chain_q[LO +: CRS_BYTE_BITS] <= {chain_q[LO +: CRS_BYTE_BITS-1], stage_in[s]};
      end
    end
  end

  // cascade out to the next card; of the 16 bytes sent, the first
  // four pass straight through this card's 12 stages. the pin is
  // registered once more so the next card sees a clean level even
  // while this card's chain is moving
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cascade_q <= 1'b0;
    end else if (clk_en) begin
      // RQ12 surplus bytes pass on
      cascade_q <= chain_q[CRS_RELAY_BITS-1];
    end
  end

  // output latches are transparent while strobe is high
  // a strobe in hold-off still loads the latches; the safeguard alone
  // decides whether the drivers may follow them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= '0;
    end else if (clk_en && lvl.strobe) begin
      // RQ14 strobe latches chain
      latch_q <= chain_q;
    end
  end

  // safeguard: hold-off, then disabled until the first strobe.
  // a strobe inside the hold-off is ignored, so a glitch while the
  // backplane powers up cannot enable the relays. the hold-off is
  // counted in clocks, so it scales with the clock rate; the enabled
  // state is left only through reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      guard_q    <= CRS_GUARD_HOLDOFF;
      hold_cnt_q <= '0;
    end else if (clk_en) begin
      case (guard_q)
        CRS_GUARD_HOLDOFF: begin
          // RQ18 power-up hold-off
          if (hold_cnt_q >= CRS_HOLD_W'(HOLDOFF_CYCLES - 1)) begin
            guard_q <= CRS_GUARD_DISABLED;
          end else begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
          end
        end
        CRS_GUARD_DISABLED: begin
          // RQ17 first strobe enables
          if (lvl.strobe) begin
            guard_q <= CRS_GUARD_ENABLED;
          end
        end
        CRS_GUARD_ENABLED: begin
          // sticky until reset
          guard_q <= CRS_GUARD_ENABLED;
        end
        default: begin
          // illegal code: back to the hold-off state, the safe direction; the count is not cleared
          guard_q <= CRS_GUARD_HOLDOFF;
        end
      endcase
    end
  end

  // output enable, registered from the safeguard state
  // the drivers read this register, so they follow one clock later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_n_q <= 1'b1;
    end else if (clk_en) begin
      // RQ16 disabled until enabled state
      oe_n_q <= (guard_q != CRS_GUARD_ENABLED);
    end
  end

  // driver outputs: a latched one closes the relay by pulling low;
  // while disabled every output sits high (relay de-energized)
  // forcing high keeps every coil dead even if the latches hold
  // leftovers from a strobe during hold-off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_n_q <= '1;
    end else if (clk_en) begin
      // RQ15 low energizes
      drive_n_q <= oe_n_q ? '1 : ~latch_q;
    end
  end

  // port drive; every output comes straight from a flip-flop
  // so nothing combinational reaches the backplane
  assign identity_serial_out    = id_out_q;
  assign identity_serial_oe     = id_oe_q;
  assign relay_drive_n          = drive_n_q;
  assign driver_output_enable_n = oe_n_q;
  assign relay_serial_cascade   = cascade_q;

endmodule

// ==== src/crs_pkg.sv ====
package crs_pkg;

  // clock rate and power-up hold-off
  localparam int unsigned CRS_CLK_MHZ        = 200;
  localparam int unsigned CRS_HOLDOFF_US     = 2209000;
  localparam int unsigned CRS_HOLDOFF_CYCLES = CRS_HOLDOFF_US * CRS_CLK_MHZ;
  localparam int unsigned CRS_HOLD_W         = 32;

  // identification image
  localparam int unsigned CRS_ROM_AW      = 9;
  localparam int unsigned CRS_ROM_DEPTH   = 512;
  localparam int unsigned CRS_IMAGE_BYTES = 498;
  localparam int unsigned CRS_BYTE_BITS   = 8;
  localparam int unsigned CRS_BITCNT_W    = 4;
  localparam logic [3:0]  CRS_BITS_FULL   = 4'h8;

  // image layout: location 0 unused, then identity, settling, table
  localparam int unsigned CRS_LOC_ID     = 1;
  localparam int unsigned CRS_LOC_SETTLE = 2;
  localparam int unsigned CRS_LOC_TABLE  = 3;
  // arbitrary card identity code
  localparam logic [7:0]  CRS_CARD_ID    = 8'h5A;
  localparam logic [7:0]  CRS_SETTLE_MS  = 8'h03;
  localparam logic [7:0]  CRS_ROM_BLANK  = 8'hFF;
  localparam logic [7:0]  CRS_ROM_ZERO   = 8'h00;

  // relay driver chain
  localparam int unsigned CRS_STAGES      = 12;
  localparam int unsigned CRS_RELAY_BITS  = CRS_STAGES * CRS_BYTE_BITS;
  localparam int unsigned CRS_FRAME_BYTES = 16;

  // backplane pins from outside the clock domain
  typedef struct packed {
    logic card_select_n;
    logic rom_address_clear;
    logic rom_address_advance_n;
    logic link_clk;
    logic relay_serial_in;
    logic strobe;
  } crs_pins_t;

  localparam int unsigned CRS_PIN_W   = $bits(crs_pins_t);
  localparam crs_pins_t   CRS_PINS_RST = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  // power-on safeguard states
  typedef enum logic [1:0] {
    CRS_GUARD_HOLDOFF,
    CRS_GUARD_DISABLED,
    CRS_GUARD_ENABLED
  } crs_guard_t;

  // image content: identity, settling time, crosspoint to relay table
  function automatic logic [7:0] crs_rom_byte(input int unsigned loc);
    logic [7:0] b;
    b = CRS_ROM_BLANK;
    if (loc == 0) begin
      b = CRS_ROM_ZERO;
    end else if (loc == CRS_LOC_ID) begin
      b = CRS_CARD_ID;
    end else if (loc == CRS_LOC_SETTLE) begin
      b = CRS_SETTLE_MS;
    end else if (loc <= CRS_IMAGE_BYTES) begin
      b = 8'((loc - CRS_LOC_TABLE) % CRS_RELAY_BITS);
    end
    return b;
  endfunction

endpackage

// ==== bench/crs_card_props.sv ====
module crs_card_props
  import crs_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES = CRS_HOLDOFF_CYCLES
) (
  // clock and reset
  input logic                      clk,
  input logic                      reset_n,
  input logic                      clk_en,
  // backplane side
  input crs_pkg::crs_pins_t        pins,
  input logic                      identity_serial_out,
  input logic                      identity_serial_oe,
  // relay side
  input logic [CRS_RELAY_BITS-1:0] relay_drive_n,
  input logic                      driver_output_enable_n,
  input logic                      relay_serial_cascade
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] hold_q;
  logic [3:0]  rise_q;
  logic        link_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // cycles since reset, saturating so it never wraps
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= 32'h0;
    end else if (clk_en && hold_q < HOLDOFF_CYCLES) begin
      hold_q <= hold_q + 32'h1;
    end
  end
  // link rises seen while the id pin is driven
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_q <= 1'b0;
      rise_q <= 4'h0;
    end else begin
      link_q <= pins.link_clk;
      if (!identity_serial_oe) begin
        rise_q <= 4'h0;
      end else if (pins.link_clk && !link_q) begin
        rise_q <= rise_q + 4'h1;
      end
    end
  end
  property p_sel_gate;
    pins.card_select_n [*8] |-> !identity_serial_oe;
  endproperty
  a_sel_gate: assert property (p_sel_gate)
    else $error("id pin driven while deselected");
  property p_load_cause;
    $rose(identity_serial_oe) |-> !$past(pins.rom_address_advance_n, 5);
  endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("id pin driven without a load");
  property p_byte_len;
    rise_q <= 4'h8;
  endproperty
  a_byte_len: assert property (p_byte_len)
    else $error("id pin driven past eight bits");
  property p_casc;
    !pins.link_clk [*8] |-> $stable(relay_serial_cascade);
  endproperty
  a_casc: assert property (p_casc)
    else $error("cascade moved without link clock");
  property p_latch_hold;
    !pins.strobe [*8] |-> $stable(relay_drive_n);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("drivers moved without strobe");
  property p_off_dis;
    driver_output_enable_n |-> &relay_drive_n;
  endproperty
  a_off_dis: assert property (p_off_dis)
    else $error("relay energized while disabled");
  property p_stay_en;
    !driver_output_enable_n |=> !driver_output_enable_n;
  endproperty
  a_stay_en: assert property (p_stay_en)
    else $error("outputs disabled again");
  property p_en_cause;
    $fell(driver_output_enable_n) |-> $past(pins.strobe, 5);
  endproperty
  a_en_cause: assert property (p_en_cause)
    else $error("outputs enabled without strobe");
  property p_hold;
    hold_q < HOLDOFF_CYCLES |-> driver_output_enable_n;
  endproperty
  a_hold: assert property (p_hold)
    else $error("outputs enabled during hold-off");
endmodule

// ==== bench/crs_ctl_model.sv ====
module crs_ctl_model
  import crs_pkg::*;
(
  // clock
  input  logic               clk,
  // backplane pins
  output crs_pkg::crs_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = CRS_PINS_RST;
  // all pins move on falling edges only
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic select(input logic s_n);
    pins.card_select_n = s_n;
    idle(6);
  endtask
  task automatic clear_addr();
    pins.rom_address_clear = 1'b1;
    idle(6);
    pins.rom_address_clear = 1'b0;
    idle(6);
  endtask
  task automatic advance();
    pins.rom_address_advance_n = 1'b0;
    idle(8);
    pins.rom_address_advance_n = 1'b1;
    idle(8);
  endtask
  task automatic link_bit(input logic d);
    pins.relay_serial_in = d;
    idle(8);
    pins.link_clk = 1'b1;
    idle(8);
    pins.link_clk = 1'b0;
  endtask
  // released data line shows the inverse, not a stale level
  task automatic release_data();
    idle(1);
    pins.relay_serial_in = ~pins.relay_serial_in;
  endtask
  task automatic strobe();
    pins.strobe = 1'b1;
    idle(10);
    pins.strobe = 1'b0;
    idle(12);
  endtask
endmodule

// ==== bench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import crs_pkg::*;
  localparam int unsigned HOLD = 40;
  logic                      clk;
  logic                      reset_n;
  logic                      clk_en;
  crs_pins_t                 pins;
  logic                      id_out;
  logic                      id_oe;
  logic                      oe_n;
  logic                      casc;
  logic [CRS_RELAY_BITS-1:0] drive_n;
  wire                       id_wire;
  int                        fails;
  int                        total_checks;
  // wire level as the controller sees it
  assign id_wire = id_oe ? id_out : 1'bz;
  crs_ctl_model u_ctl (.clk(clk), .pins(pins));
  crs_card #(.HOLDOFF_CYCLES(HOLD)) u_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .pins(pins), .identity_serial_out(id_out), .identity_serial_oe(id_oe),
    .relay_drive_n(drive_n), .driver_output_enable_n(oe_n), .relay_serial_cascade(casc));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // comparisons
  task automatic chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_vec(input string n, input logic [95:0] e, input logic [95:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // expected image byte at a location
  function automatic logic [7:0] img(input int loc);
    if (loc == 1) return CRS_CARD_ID;
    if (loc == 2) return CRS_SETTLE_MS;
    return 8'((loc - 3) % CRS_RELAY_BITS);
  endfunction
  // one load and eight shifts; bounded wait for the pin to drive
  task automatic read_byte(output logic [7:0] b);
    int k;
    u_ctl.advance();
    k = 0;
    while (id_oe !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (k == 20) begin
      fails++;
      $display("[FAIL] id_oe expected 1 seen %b", id_oe);
      final_report();
    end
    for (int i = 7; i >= 0; i--) begin
      b[i] = id_wire;
      u_ctl.link_bit(1'b0);
    end
    u_ctl.idle(2);
    chk_bit("id_wire idle", 1'bz, id_wire);
  endtask
  task automatic t_holdoff();
    chk_bit("oe_n reset", 1'b1, oe_n);
    chk_vec("drive reset", '1, drive_n);
    u_ctl.strobe();
    chk_bit("oe_n holdoff", 1'b1, oe_n);
    $display("t_holdoff done");
  endtask
  task automatic t_readout();
    logic [7:0] b;
    u_ctl.select(1'b0);
    u_ctl.clear_addr();
    for (int loc = 1; loc <= 498; loc++) begin
      read_byte(b);
      chk_vec("id byte", 96'(img(loc)), 96'(b));
    end
    u_ctl.clear_addr();
    read_byte(b);
    chk_vec("id byte after clear", 96'(img(1)), 96'(b));
    $display("t_readout done");
  endtask
  task automatic t_deselect();
    u_ctl.select(1'b1);
    u_ctl.advance();
    chk_bit("oe deselected", 1'b0, id_oe);
    repeat (8) u_ctl.link_bit(1'b1);
    chk_bit("oe deselected", 1'b0, id_oe);
    $display("t_deselect done");
  endtask
  task automatic send_frame(input logic [127:0] p);
    for (int i = 127; i >= 0; i--) u_ctl.link_bit(p[i]);
    u_ctl.release_data();
  endtask
  task automatic t_relay();
    logic [127:0] p1;
    logic [127:0] p2;
    p1 = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    p2 = {p1[63:0], p1[127:64]};
    send_frame(p1);
    chk_bit("cascade", p1[95], casc);
    chk_vec("drive before strobe", '1, drive_n);
    u_ctl.strobe();
    chk_bit("oe_n after strobe", 1'b0, oe_n);
    chk_vec("drive frame1", ~p1[95:0], drive_n);
    send_frame(p2);
    chk_vec("drive held", ~p1[95:0], drive_n);
    u_ctl.strobe();
    chk_vec("drive frame2", ~p2[95:0], drive_n);
    chk_bit("oe_n stays", 1'b0, oe_n);
    // clock enable low: a whole frame and strobe must leave no trace
    clk_en = 1'b0;
    send_frame(p1);
    u_ctl.strobe();
    chk_vec("drive frozen", ~p2[95:0], drive_n);
    chk_bit("cascade frozen", p2[95], casc);
    clk_en = 1'b1;
    u_ctl.strobe();
    chk_vec("drive after thaw", ~p2[95:0], drive_n);
    $display("t_relay done");
  endtask
  initial begin
    fails = 0;
    total_checks = 0;
    clk_en = 1'b1;
    reset_n = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    t_holdoff();
    // identity readout once, straight after power-up
    t_readout();
    t_deselect();
    t_relay();
    final_report();
  end
endmodule
bind crs_card crs_card_props #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) u_props (.clk(clk),
  .reset_n(reset_n), .clk_en(clk_en), .pins(pins), .identity_serial_out(identity_serial_out),
  .identity_serial_oe(identity_serial_oe), .relay_drive_n(relay_drive_n),
  .driver_output_enable_n(driver_output_enable_n), .relay_serial_cascade(relay_serial_cascade));
